// [pfh_pkg.sv]
// constants, field layouts and carrier types for the PHY packet framer
// assumes one clock domain and a synchronous active-high reset
package pfh_pkg;

	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0]  OFF_NODE_ID   = 8'h00;
	localparam logic [7:0]  OFF_STATUS    = 8'h04;
	localparam logic [7:0]  OFF_TX_FIRST  = 8'h80;
	localparam logic [7:0]  OFF_TX_CONT   = 8'h84;
	localparam logic [7:0]  OFF_TX_COMMIT = 8'h8C;

	localparam int          NODE_LSB      = 0;
	localparam int          PHYID_LSB     = 16;
	localparam logic [15:0] NODE_RESET    = 16'h0000;
	localparam logic [5:0]  PHYID_RESET   = 6'h00;

	localparam int          ST_TX_PEND    = 0;
	localparam int          ST_TX_REFUSED = 1;
	localparam int          ST_HDR_ERR    = 2;
	localparam int          ST_RX_DROP    = 3;
	localparam int          ST_LINK_ON    = 4;
	localparam int          ST_FORCE_ROOT = 5;
	localparam int          ST_DISCARD    = 6;
	localparam int          ST_GAP_LSB    = 8;

	// ---------------------------------------------------------------
	// PHY packet first quadlet (bit 31 is the first bit on the wire)
	// ---------------------------------------------------------------
	localparam logic [31:0] UNFMT_CODE    = 32'h0000_00E0;
	localparam int          PK_ID_LSB     = 30;
	localparam int          PK_NODE_LSB   = 24;
	localparam int          PK_R_BIT      = 23;
	localparam int          PK_T_BIT      = 22;
	localparam int          PK_GAP_LSB    = 16;
	localparam int          PK_DEST_LSB   = 16;
	localparam logic [1:0]  ID_PHY_CFG    = 2'h0;
	localparam logic [1:0]  ID_LINK_ON    = 2'h1;
	localparam logic [5:0]  GAP_DEFAULT   = 6'h3F;
	localparam logic [1:0]  GAP_AGE_MAX   = 2'h2;

	// ---------------------------------------------------------------
	// receive token quadlet
	// ---------------------------------------------------------------
	localparam int          TOK_SPD_LSB   = 30;
	localparam int          TOK_CNT_LSB   = 16;
	localparam int          TOK_RES_LSB   = 12;
	localparam int          TOK_TC_LSB    = 4;
	localparam logic [3:0]  TCODE_SELFID  = 4'hE;
	localparam logic [3:0]  RES_PHY_PKT   = 4'h0;
	localparam logic [3:0]  ACK_COMPLETE  = 4'h1;
	localparam logic [3:0]  ACK_DATA_ERR  = 4'hD;
	localparam logic [1:0]  SPD_S100      = 2'h0;

	// ---------------------------------------------------------------
	// storage sizes
	// ---------------------------------------------------------------
	localparam int          TX_DEPTH      = 4;
	localparam int          TX_CW         = 3;
	localparam int          SID_DEPTH     = 16;
	localparam int          SID_CW        = 5;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		logic        first;
		logic        last;
		logic        selfid;
		logic [1:0]  speed;
		logic [3:0]  result;
		logic [31:0] data;
	} pfh_rx_beat_t;

	typedef struct packed {
		logic        valid;
		logic        last;
		logic [31:0] data;
	} pfh_tx_beat_t;

	typedef struct packed {
		logic        we;
		logic [31:0] data;
	} pfh_grq_wr_t;

endpackage

// [pfh_pkt_check.sv]
// decoder for a received two-quadlet PHY packet
// assumes q0 and q1 are the first and second quadlets as received
`timescale 1ns/1ps
module pfh_pkt_check
	import pfh_pkg::*;
(
	input  wire logic [31:0] q0,
	input  wire logic [31:0] q1,
	input  wire logic [15:0] node_id,
	input  wire logic [5:0]  target_node_id,
	output logic             inverse_ok,
	output logic             is_cfg,
	output logic             is_link_on,
	output logic             is_reserved,
	output logic             root_match,
	output logic             force_root_flag,
	output logic             gap_update,
	output logic [5:0]       gap,
	output logic             target_match,
	output logic             dest_match
);
	logic [5:0] node_field;

	always_comb begin
		node_field      = q0[PK_NODE_LSB +: 6];
		inverse_ok      = (q1 == ~q0);
		is_cfg          = (q0[PK_ID_LSB +: 2] == ID_PHY_CFG);
		is_link_on      = (q0[PK_ID_LSB +: 2] == ID_LINK_ON);
		force_root_flag = q0[PK_R_BIT];
		gap_update      = q0[PK_T_BIT];
		gap             = q0[PK_GAP_LSB +: 6];
		is_reserved     = is_cfg && !force_root_flag && !gap_update;
		root_match      = (node_field == target_node_id);
		target_match    = (node_field == target_node_id);
		// upper half looks like a destination id to the header check
		dest_match      = (q0[PK_DEST_LSB +: 16] == node_id);
	end
endmodule

// [pfh_framer.sv]
// PHY packet framer: transmit queue ports and PHY packet receive packing
// assumes the link receiver and transmitter run on ref_clk and hand over
// quadlets as beats; the general receive queue never refuses a write
//
// How it works
// - configuration packets carry identifier 00 in their top two bits.
// - root field names the node to force root; used only with R set.
// - with R set, force root only on the named node, else clear it.
// - with T set, load the gap count from the packet.
// - new gap count holds one bus reset, reverts to default on second.
// - configuration packet with R and T clear is ignored entirely.
// - upper half equal to our node id raises a header error.
// - link-on carries identifier 01, target id, fixed zero and one bits.
// - link-on target field names the addressed node.
// - self-id packets go out as token with code Eh, then all quadlets. The code keeps at most 16 and drops the rest.
// - token speed field carries reception speed; zero for self-id. The code loads the beat's speed for self-id packets too.
// - token quadlet count equals the quadlets that follow it.
// - token result field uses acknowledge code encoding.
// - PHY packet token has result 0000 and only the first quadlet.
// - second quadlet not inverse of first: drop packet, store nothing.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module pfh_framer
	import pfh_pkg::*;
(
	input  wire logic          ref_clk,
	input  wire logic          reset,
	input  wire logic [7:0]    addr,
	input  wire logic [31:0]   wdata,
	input  wire logic          wr,
	input  wire logic          rd,
	output logic [31:0]        rdata,
	input  wire pfh_rx_beat_t  rx_beat,
	input  wire logic          bus_reset,
	output pfh_grq_wr_t        grq_wr,
	output pfh_tx_beat_t       tx_beat,
	input  wire logic          tx_ready,
	output logic               force_root,
	output logic [5:0]         gap_count
);
	// ---------------------------------------------------------------
	// host side: node register, transmit queue, read data
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_SEND = 2'b10
	} pfh_tx_state_t;

	pfh_tx_state_t tx_state_ff, nxt_tx_state;
	logic [31:0]   tx_buf_ff [TX_DEPTH];
	logic [31:0]   nxt_tx_buf [TX_DEPTH];
	logic [TX_CW-1:0] tx_wcnt_ff, nxt_tx_wcnt;
	logic [TX_CW-1:0] tx_ridx_ff, nxt_tx_ridx;
	pfh_tx_beat_t  tx_beat_ff, nxt_tx_beat;
	logic          tx_refused_ff, nxt_tx_refused;
	logic [15:0]   node_id_ff, nxt_node_id;
	logic [5:0]    target_node_id_ff, nxt_target_node_id;
	logic [31:0]   rdata_ff, nxt_rdata;
	logic [31:0]   status;
	logic          st_clr;
	logic          wr_first, wr_cont, wr_commit;

	// receive-side state read by the host side
	logic          hdr_err_ff, rx_drop_ff, link_on_ff, discard_ff;
	logic          force_root_ff;
	logic [5:0]    gap_ff;

	always_comb begin
		st_clr    = wr && (addr == OFF_STATUS);
		wr_first  = wr && (addr == OFF_TX_FIRST);
		wr_cont   = wr && (addr == OFF_TX_CONT);
		wr_commit = wr && (addr == OFF_TX_COMMIT);
		status    = '0;
		status[ST_TX_PEND]          = (tx_state_ff == TX_SEND);
		status[ST_TX_REFUSED]       = tx_refused_ff;
		status[ST_HDR_ERR]          = hdr_err_ff;
		status[ST_RX_DROP]          = rx_drop_ff;
		status[ST_LINK_ON]          = link_on_ff;
		status[ST_FORCE_ROOT]       = force_root_ff;
		status[ST_DISCARD]          = discard_ff;
		status[ST_GAP_LSB +: 6]     = gap_ff;
	end

	always_comb begin
		nxt_tx_state   = tx_state_ff;
		nxt_tx_buf     = tx_buf_ff;
		nxt_tx_wcnt    = tx_wcnt_ff;
		nxt_tx_ridx    = tx_ridx_ff;
		nxt_tx_beat    = tx_beat_ff;
		nxt_tx_refused = tx_refused_ff && !(st_clr && wdata[ST_TX_REFUSED]);
		nxt_node_id    = node_id_ff;
		nxt_target_node_id     = target_node_id_ff;
		nxt_rdata      = '0;
		if (wr && (addr == OFF_NODE_ID)) begin
			nxt_node_id = wdata[NODE_LSB +: 16];
			nxt_target_node_id  = wdata[PHYID_LSB +: 6];
		end
		if (rd) begin
			case (addr)
				OFF_NODE_ID: nxt_rdata = {10'h000, target_node_id_ff, node_id_ff};
				OFF_STATUS:  nxt_rdata = status;
				default:     nxt_rdata = '0;
			endcase
		end
		case (tx_state_ff)
			TX_IDLE: begin
				// queue is frozen while a packet drains; writes then refused
				if (wr_first) begin
					nxt_tx_buf[0] = wdata;
					nxt_tx_wcnt   = TX_CW'(1);
				end else if (wr_cont || wr_commit) begin
					if (tx_wcnt_ff < TX_CW'(TX_DEPTH)) begin
						nxt_tx_buf[tx_wcnt_ff[1:0]] = wdata;
						nxt_tx_wcnt = tx_wcnt_ff + TX_CW'(1);
					end else begin
						nxt_tx_refused = 1'b1;
					end
					if (wr_commit) begin
						nxt_tx_state = TX_SEND;
						nxt_tx_ridx  = '0;
					end
				end
			end
			TX_SEND: begin
				if (wr_first || wr_cont || wr_commit) begin
					nxt_tx_refused = 1'b1;
				end
				if (!tx_beat_ff.valid || tx_ready) begin
					if (tx_ridx_ff < tx_wcnt_ff) begin
						nxt_tx_beat.valid = 1'b1;
						nxt_tx_beat.last  =
							(tx_ridx_ff == tx_wcnt_ff - TX_CW'(1));
						nxt_tx_beat.data  = tx_buf_ff[tx_ridx_ff[1:0]];
						nxt_tx_ridx       = tx_ridx_ff + TX_CW'(1);
					end else begin
						nxt_tx_beat  = '0;
						nxt_tx_wcnt  = '0;
						nxt_tx_state = TX_IDLE;
					end
				end
			end
			default: begin
				nxt_tx_state = TX_IDLE;
				nxt_tx_beat  = '0;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tx_state_ff   <= TX_IDLE;
			tx_buf_ff     <= '{default: '0};
			tx_wcnt_ff    <= '0;
			tx_ridx_ff    <= '0;
			tx_beat_ff    <= '0;
			tx_refused_ff <= 1'b0;
			node_id_ff    <= NODE_RESET;
			target_node_id_ff     <= PHYID_RESET;
			rdata_ff      <= '0;
		end else begin
			tx_state_ff   <= nxt_tx_state;
			tx_buf_ff     <= nxt_tx_buf;
			tx_wcnt_ff    <= nxt_tx_wcnt;
			tx_ridx_ff    <= nxt_tx_ridx;
			tx_beat_ff    <= nxt_tx_beat;
			tx_refused_ff <= nxt_tx_refused;
			node_id_ff    <= nxt_node_id;
			target_node_id_ff     <= nxt_target_node_id;
			rdata_ff      <= nxt_rdata;
		end
	end

	// ---------------------------------------------------------------
	// receive side: self-id and PHY packet packing
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		RX_IDLE   = 4'b0001,
		RX_SELFID = 4'b0010,
		RX_PHYQ1  = 4'b0100,
		RX_EMIT   = 4'b1000
	} pfh_rx_state_t;

	pfh_rx_state_t rx_state_ff, nxt_rx_state;
	logic [31:0]   sid_buf_ff [SID_DEPTH];
	logic [31:0]   nxt_sid_buf [SID_DEPTH];
	logic [SID_CW-1:0] sid_cnt_ff, nxt_sid_cnt, emit_idx_ff, nxt_emit_idx;
	logic [1:0]    spd_ff, nxt_spd;
	logic [3:0]    res_ff, nxt_res;
	logic          ovf_ff, nxt_ovf;
	logic [31:0]   q0_ff, nxt_q0;
	pfh_grq_wr_t   grq_ff, nxt_grq;
	logic [1:0]    gap_age_ff, nxt_gap_age;
	logic [5:0]    nxt_gap;
	logic          nxt_force_root, nxt_hdr_err, nxt_rx_drop;
	logic          nxt_link_on, nxt_discard;
	logic [31:0]   token, emit_src;
	logic          ck_inv, ck_cfg, ck_lon, ck_rsv, ck_root, ck_r, ck_t;
	logic          ck_tgt, ck_dest, q1_beat;
	logic [5:0]    ck_gap;

	pfh_pkt_check u_check (
		.q0              (q0_ff),
		.q1              (rx_beat.data),
		.node_id         (node_id_ff),
		.target_node_id          (target_node_id_ff),
		.inverse_ok      (ck_inv),
		.is_cfg          (ck_cfg),
		.is_link_on      (ck_lon),
		.is_reserved     (ck_rsv),
		.root_match      (ck_root),
		.force_root_flag (ck_r),
		.gap_update      (ck_t),
		.gap             (ck_gap),
		.target_match    (ck_tgt),
		.dest_match      (ck_dest)
	);

	always_comb begin
		q1_beat  = (rx_state_ff == RX_PHYQ1) && rx_beat.valid;
		token    = '0;
		token[TOK_SPD_LSB +: 2]      = spd_ff;
		token[TOK_CNT_LSB +: SID_CW] = sid_cnt_ff;
		token[TOK_RES_LSB +: 4]      = res_ff;
		token[TOK_TC_LSB +: 4]       = TCODE_SELFID;
		emit_src = (emit_idx_ff == '0) ? token
			: sid_buf_ff[4'(emit_idx_ff - SID_CW'(1))];
	end

	always_comb begin
		nxt_rx_state   = rx_state_ff;
		nxt_sid_buf    = sid_buf_ff;
		nxt_sid_cnt    = sid_cnt_ff;
		nxt_emit_idx   = emit_idx_ff;
		nxt_spd        = spd_ff;
		nxt_res        = res_ff;
		nxt_ovf        = ovf_ff;
		nxt_q0         = q0_ff;
		nxt_grq        = '0;
		nxt_gap        = gap_ff;
		nxt_gap_age    = gap_age_ff;
		nxt_force_root = force_root_ff;
		// sticky flags: a new event in the clearing cycle wins
		nxt_hdr_err = hdr_err_ff && !(st_clr && wdata[ST_HDR_ERR]);
		nxt_rx_drop = rx_drop_ff && !(st_clr && wdata[ST_RX_DROP]);
		nxt_link_on = link_on_ff && !(st_clr && wdata[ST_LINK_ON]);
		nxt_discard = discard_ff && !(st_clr && wdata[ST_DISCARD]);
		if (bus_reset && (gap_age_ff != GAP_AGE_MAX)) begin
			nxt_gap_age = gap_age_ff + 2'h1;
			if (gap_age_ff == 2'h1) begin
				nxt_gap = GAP_DEFAULT;
			end
		end
		case (rx_state_ff)
			RX_IDLE: begin
				if (rx_beat.valid && rx_beat.first) begin
					nxt_spd = rx_beat.speed;
					if (rx_beat.selfid) begin
						nxt_sid_buf[0] = rx_beat.data;
						nxt_sid_cnt    = SID_CW'(1);
						nxt_ovf        = 1'b0;
						nxt_res        = rx_beat.result;
						nxt_emit_idx   = '0;
						nxt_rx_state   = rx_beat.last ? RX_EMIT : RX_SELFID;
					end else begin
						nxt_q0       = rx_beat.data;
						nxt_rx_state = RX_PHYQ1;
					end
				end else if (rx_beat.valid) begin
					nxt_rx_drop = 1'b1;
				end
			end
			RX_SELFID: begin
				if (rx_beat.valid) begin
					// a full buffer truncates the list and marks a data error
					if (sid_cnt_ff < SID_CW'(SID_DEPTH)) begin
						nxt_sid_buf[sid_cnt_ff[3:0]] = rx_beat.data;
						nxt_sid_cnt = sid_cnt_ff + SID_CW'(1);
					end else begin
						nxt_ovf = 1'b1;
					end
					if (rx_beat.last) begin
						nxt_res = (ovf_ff || !(sid_cnt_ff < SID_CW'(SID_DEPTH)))
							? ACK_DATA_ERR : rx_beat.result;
						nxt_rx_state = RX_EMIT;
					end
				end
			end
			RX_PHYQ1: begin
				if (rx_beat.valid) begin
					nxt_rx_state = RX_IDLE;
					if (!ck_inv) begin
						nxt_discard = 1'b1;
					end else if (ck_rsv) begin
						nxt_rx_state = RX_IDLE;
					end else begin
						if (ck_dest) begin
							nxt_hdr_err = 1'b1;
						end
						if (ck_cfg) begin
							if (ck_r) begin
								nxt_force_root = ck_root;
							end
							if (ck_t) begin
								nxt_gap     = ck_gap;
								nxt_gap_age = '0;
							end
						end else if (ck_lon && ck_tgt) begin
							nxt_link_on = 1'b1;
						end
						nxt_sid_buf[0] = q0_ff;
						nxt_sid_cnt    = SID_CW'(1);
						nxt_res        = RES_PHY_PKT;
						nxt_emit_idx   = '0;
						nxt_rx_state   = RX_EMIT;
					end
				end
			end
			RX_EMIT: begin
				if (rx_beat.valid) begin
					nxt_rx_drop = 1'b1;
				end
				nxt_grq.we   = 1'b1;
				nxt_grq.data = emit_src;
				nxt_emit_idx = emit_idx_ff + SID_CW'(1);
				if (emit_idx_ff == sid_cnt_ff) begin
					nxt_rx_state = RX_IDLE;
				end
			end
			default: nxt_rx_state = RX_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rx_state_ff   <= RX_IDLE;
			sid_buf_ff    <= '{default: '0};
			sid_cnt_ff    <= '0;
			emit_idx_ff   <= '0;
			spd_ff        <= SPD_S100;
			res_ff        <= ACK_COMPLETE;
			ovf_ff        <= 1'b0;
			q0_ff         <= '0;
			grq_ff        <= '0;
			gap_ff        <= GAP_DEFAULT;
			gap_age_ff    <= GAP_AGE_MAX;
			force_root_ff <= 1'b0;
			hdr_err_ff    <= 1'b0;
			rx_drop_ff    <= 1'b0;
			link_on_ff    <= 1'b0;
			discard_ff    <= 1'b0;
		end else begin
			rx_state_ff   <= nxt_rx_state;
			sid_buf_ff    <= nxt_sid_buf;
			sid_cnt_ff    <= nxt_sid_cnt;
			emit_idx_ff   <= nxt_emit_idx;
			spd_ff        <= nxt_spd;
			res_ff        <= nxt_res;
			ovf_ff        <= nxt_ovf;
			q0_ff         <= nxt_q0;
			grq_ff        <= nxt_grq;
			gap_ff        <= nxt_gap;
			gap_age_ff    <= nxt_gap_age;
			force_root_ff <= nxt_force_root;
			hdr_err_ff    <= nxt_hdr_err;
			rx_drop_ff    <= nxt_rx_drop;
			link_on_ff    <= nxt_link_on;
			discard_ff    <= nxt_discard;
		end
	end

	always_comb begin
		rdata      = rdata_ff;
		tx_beat    = tx_beat_ff;
		grq_wr     = grq_ff;
		force_root = force_root_ff;
		gap_count  = gap_ff;
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_discard;
		@(posedge ref_clk) disable iff (reset)
		(q1_beat && !ck_inv) |=> (!grq_ff.we && rx_state_ff == RX_IDLE);
	endproperty
	a_discard: assert property (p_discard)
		else $error("bad PHY packet was not discarded");

	property p_reserved;
		@(posedge ref_clk) disable iff (reset)
		(q1_beat && ck_inv && ck_rsv && !bus_reset)
			|=> $stable(gap_ff) && $stable(force_root_ff) ##1 !grq_ff.we;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved config packet had an effect");

	property p_gap_load;
		@(posedge ref_clk) disable iff (reset)
		(q1_beat && ck_inv && ck_cfg && ck_t) |=> gap_ff == $past(ck_gap);
	endproperty
	a_gap_load: assert property (p_gap_load)
		else $error("gap count not loaded from packet");

	property p_force_root;
		@(posedge ref_clk) disable iff (reset)
		(q1_beat && ck_inv && ck_cfg && ck_r)
			|=> force_root_ff == $past(ck_root);
	endproperty
	a_force_root: assert property (p_force_root)
		else $error("force root not set from root field");

	property p_gap_revert;
		@(posedge ref_clk) disable iff (reset)
		(bus_reset && gap_age_ff == 2'h1 && !q1_beat)
			|=> gap_ff == GAP_DEFAULT;
	endproperty
	a_gap_revert: assert property (p_gap_revert)
		else $error("gap count did not revert on second bus reset");

	property p_phy_token;
		@(posedge ref_clk) disable iff (reset)
		(rx_state_ff == RX_EMIT && emit_idx_ff == '0 && res_ff == RES_PHY_PKT)
			|=> grq_ff.we && grq_ff.data[TOK_RES_LSB +: 4] == 4'h0
			&& grq_ff.data[TOK_CNT_LSB +: SID_CW] == SID_CW'(1)
			##1 grq_ff.we ##1 !grq_ff.we;
	endproperty
	a_phy_token: assert property (p_phy_token)
		else $error("PHY packet token or length wrong");

	property p_token_code;
		@(posedge ref_clk) disable iff (reset)
		$rose(grq_ff.we) |-> grq_ff.data[TOK_TC_LSB +: 4] == TCODE_SELFID;
	endproperty
	a_token_code: assert property (p_token_code)
		else $error("first queue write is not a token");

	property p_order;
		@(posedge ref_clk) disable iff (reset)
		(rx_state_ff == RX_EMIT && emit_idx_ff != '0)
			|=> grq_ff.we && grq_ff.data == $past(emit_src);
	endproperty
	a_order: assert property (p_order)
		else $error("self-id quadlet out of order");

	property p_commit_only;
		@(posedge ref_clk) disable iff (reset)
		(tx_state_ff == TX_IDLE && (wr_first || wr_cont))
			|=> tx_state_ff == TX_IDLE && !tx_beat_ff.valid;
	endproperty
	a_commit_only: assert property (p_commit_only)
		else $error("packet sent without commit write");

	property p_hdr_err;
		@(posedge ref_clk) disable iff (reset)
		(q1_beat && ck_inv && !ck_rsv && ck_dest) |=> hdr_err_ff;
	endproperty
	a_hdr_err: assert property (p_hdr_err)
		else $error("header error not raised");
endmodule

// [pfh_phy_model.sv]
// far-side model: link receiver beats and a stalling transmitter
// assumes the framer samples beats on the rising edge of ref_clk
`timescale 1ns/1ps
module pfh_phy_model
	import pfh_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire pfh_tx_beat_t tx_beat,
	output pfh_rx_beat_t      rx_beat,
	output logic              tx_ready
);
	logic [32:0] tx_q[$];
	logic [1:0]  stall_ff = 2'h0;
	initial rx_beat = '0;
	// ready two cycles in three, so a held beat is exercised
	always @(posedge ref_clk) begin
		stall_ff <= (stall_ff == 2'h2) ? 2'h0 : stall_ff + 2'h1;
		if (tx_beat.valid && tx_ready)
			tx_q.push_back({tx_beat.last, tx_beat.data});
	end
	assign tx_ready = (stall_ff != 2'h0);
	task send(input logic [31:0] d, input logic f, l, s, input logic [3:0] r);
		@(posedge ref_clk);
		rx_beat <= '{1'b1, f, l, s, SPD_S100, r, d};
	endtask
	// released data shows the inverse, so a stale value is never trusted
	task release_rx();
		@(posedge ref_clk);
		rx_beat <= '{1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 4'h0, ~rx_beat.data};
	endtask
endmodule

// [pfh_framer_test.sv]
// self-checking bench for the PHY packet framer
// assumes pfh_pkg and pfh_phy_model are compiled before it
`timescale 1ns/1ps
module pfh_framer_test
	import pfh_pkg::*;
;
	logic         ref_clk = 1'b0;
	logic         reset = 1'b1;
	logic [7:0]   addr = 8'h00;
	logic [31:0]  wdata = 32'h0000_0000;
	logic         wr = 1'b0;
	logic         rd = 1'b0;
	logic         bus_reset = 1'b0;
	logic [31:0]  rdata, got, q, seed = 32'h37D3;
	logic         tx_ready, force_root;
	logic [5:0]   gap_count;
	pfh_rx_beat_t rx_beat;
	pfh_tx_beat_t tx_beat;
	pfh_grq_wr_t  grq_wr;
	logic [31:0]  grq_q[$];
	logic [31:0]  sid[4];
	logic [3:0]   codes[2] = '{ACK_COMPLETE, ACK_DATA_ERR};
	int           fail_count = 0;
	int           checks_done = 0;

	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (grq_wr.we) grq_q.push_back(grq_wr.data);

	pfh_framer pfh_framer_inst (.ref_clk(ref_clk), .reset(reset),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.rx_beat(rx_beat), .bus_reset(bus_reset), .grq_wr(grq_wr),
		.tx_beat(tx_beat), .tx_ready(tx_ready), .force_root(force_root),
		.gap_count(gap_count));
	pfh_phy_model pfh_phy_model_inst (.ref_clk(ref_clk), .tx_beat(tx_beat),
		.rx_beat(rx_beat), .tx_ready(tx_ready));

	// ----------------------------------------------------------
	// helpers
	// ----------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [31:0] tok(input logic [4:0] n, input logic [3:0] r);
		return {SPD_S100, 9'h000, n, r, 4'h0, TCODE_SELFID, 4'h0};
	endfunction
	task chk(input logic [32:0] g, input logic [32:0] e);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task end_of_test();
		if (fail_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	task rd_reg(input logic [7:0] a);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 got = rdata;
	endtask
	// waits for n quadlets, then leaves room for any stray extra one
	task grq_wait(input int n);
		for (int i = 0; i < 40 && grq_q.size() < n; i++) @(posedge ref_clk);
		if (grq_q.size() < n) begin
			fail_count++;
			$display("BAD %0t receive queue timeout", $time);
			end_of_test();
		end
		repeat (6) @(posedge ref_clk);
	endtask
	task phy_pkt(input logic [31:0] q0, input logic [31:0] q1, input int n);
		grq_q.delete();
		pfh_phy_model_inst.send(q0, 1'b1, 1'b0, 1'b0, 4'h0);
		pfh_phy_model_inst.send(q1, 1'b0, 1'b1, 1'b0, 4'h0);
		pfh_phy_model_inst.release_rx();
		grq_wait(n);
	endtask

	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	initial begin
		repeat (12) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		#1 chk(33'(gap_count), 33'h3F);
		chk(33'(force_root), 33'h0);
		// bus/node id deliberately lacks the top bit, target_node_id 05h
		wr_reg(OFF_NODE_ID, 32'h0005_4500);
		rd_reg(OFF_TX_FIRST);
		chk(33'(got), 33'h0);
		q = rnd();
		q = {ID_LINK_ON, q[29:24], 8'h00, 16'h00E0};
		wr_reg(OFF_TX_FIRST, UNFMT_CODE);
		wr_reg(OFF_TX_CONT, q);
		repeat (8) @(posedge ref_clk);
		chk(33'(pfh_phy_model_inst.tx_q.size()), 33'h0);
		wr_reg(OFF_TX_COMMIT, {~q[31:16], 16'hFFFF});
		// a write while the packet drains must not reach the queue
		wr_reg(OFF_TX_CONT, rnd());
		for (int i = 0; i < 40 && pfh_phy_model_inst.tx_q.size() < 3; i++)
			@(posedge ref_clk);
		if (pfh_phy_model_inst.tx_q.size() < 3) begin
			fail_count++;
			$display("BAD %0t transmit timeout", $time);
			end_of_test();
		end
		chk(33'(pfh_phy_model_inst.tx_q.size()), 33'h3);
		chk(pfh_phy_model_inst.tx_q[0], {1'b0, UNFMT_CODE});
		chk(pfh_phy_model_inst.tx_q[1], {1'b0, q});
		chk(pfh_phy_model_inst.tx_q[2], {1'b1, ~q[31:16], 16'hFFFF});
		foreach (codes[k]) begin
			grq_q.delete();
			for (int i = 0; i <= k + 1; i++) begin
				sid[i] = rnd();
				pfh_phy_model_inst.send(sid[i], i == 0, i == k + 1, 1'b1, codes[k]);
			end
			pfh_phy_model_inst.release_rx();
			grq_wait(k + 3);
			chk(33'(grq_q.size()), 33'(k + 3));
			chk(33'(grq_q[0]), 33'(tok(5'(k + 2), codes[k])));
			for (int i = 0; i <= k + 1; i++)
				chk(33'(grq_q[i + 1]), 33'(sid[i]));
		end
		// force root on our node with a new gap count
		phy_pkt(32'h05EA_00E0, 32'hFA15_FF1F, 2);
		chk(33'(grq_q.size()), 33'h2);
		chk(33'(grq_q[0]), 33'(tok(5'h01, RES_PHY_PKT)));
		chk(33'(grq_q[1]), 33'h05EA_00E0);
		chk(33'(force_root), 33'h1);
		chk(33'(gap_count), 33'h2A);
		phy_pkt(32'h0680_00E0, 32'hF97F_FF1F, 2);
		chk(33'(force_root), 33'h0);
		phy_pkt(32'h0500_00E0, 32'hFAFF_FF1F, 0);
		chk(33'(grq_q.size()), 33'h0);
		// bad check word on a packet that would force root and load gap 0
		phy_pkt(32'h05C0_00E0, 32'h05C0_00E0, 0);
		chk(33'(grq_q.size()), 33'h0);
		chk(33'(gap_count), 33'h2A);
		chk(33'(force_root), 33'h0);
		// link-on aimed at us whose upper half equals our node id
		phy_pkt(32'h4500_00E0, 32'hBAFF_FF1F, 2);
		chk(33'(grq_q[1]), 33'h4500_00E0);
		rd_reg(OFF_STATUS);
		chk(33'(got[ST_TX_REFUSED]), 33'h1);
		chk(33'(got[ST_HDR_ERR]), 33'h1);
		chk(33'(got[ST_LINK_ON]), 33'h1);
		for (int i = 0; i < 2; i++) begin
			@(posedge ref_clk);
			bus_reset <= 1'b1;
			@(posedge ref_clk);
			bus_reset <= 1'b0;
			repeat (3) @(posedge ref_clk);
			chk(33'(gap_count), (i == 0) ? 33'h2A : 33'h3F);
		end
		end_of_test();
	end
endmodule
